// ==== include/otpc_map.svh ====
/*
 * constants for the one-time-programmable memory host controller:
 * geometry, identification addresses and pin timing in sys_clk cycles.
 * assumes a 25 MHz sys_clk; times are kept in ns or us beside the counts.
 */
`ifndef OTPC_MAP_SVH
`define OTPC_MAP_SVH

`define OTPC_ADDR_W 16
`define OTPC_DATA_W 8
`define OTPC_LAST_ADDR 16'hffff
`define OTPC_ERASED_BYTE 8'hff
`define OTPC_CLK_NS 40
// access delay of the part, longest grade, ns
`define OTPC_ACCESS_NS 90
`define OTPC_ACCESS_CYC ((`OTPC_ACCESS_NS + `OTPC_CLK_NS - 1) / `OTPC_CLK_NS)
// verify sample delay after select falls, ns
`define OTPC_VERIFY_NS 100
`define OTPC_VERIFY_CYC ((`OTPC_VERIFY_NS + `OTPC_CLK_NS - 1) / `OTPC_CLK_NS)
// programming pulse, least and longest, us
`define OTPC_PULSE_MIN_US 20
`define OTPC_PULSE_MAX_US 100
`define OTPC_PULSE_CYC \
  ((`OTPC_PULSE_MIN_US * 1000 + `OTPC_CLK_NS - 1) / `OTPC_CLK_NS)
`define OTPC_MAX_PULSES 25
`define OTPC_ID_MFR_ADDR 16'h0202
`define OTPC_ID_DEV_ADDR 16'h0203
`define OTPC_ID_CONT_ADDR 16'h0200
`define OTPC_CNT_W 10
`define OTPC_PCNT_W 5

`endif

// ==== include/otpc_pkg.sv ====
/*
 * types for the memory host controller.
 * assumes otpc_map.svh is on the include path.
 */
package otpc_pkg;
  typedef enum logic [1:0] {
    OTPC_CMD_READ,
    OTPC_CMD_PROG,
    OTPC_CMD_ID,
    OTPC_CMD_VERIFY_ALL
  } otpc_cmd_t;
endpackage

// ==== hdl/otpc_host.sv ====
/*
 * host controller driving a 64K x 8 one-time-programmable memory by pins:
 * reads, identification reads, pulse-and-verify byte programming and a
 * full read-back compare against an expected value.
 * assumes the memory pins are sampled synchronously to sys_clk and that
 * the board turns prog_voltage_en / id_high_voltage into the real levels.
 */
// Function
// - program mode needs programming voltage present and select low
// - in program mode host drives all 8 data bits in parallel
// - pulse 20..100 us, verify after each, stop on pass or max count
// - step each address in turn, then read back the whole memory
// - parallel parts share all inputs except separate selects
// - verify reads with gate and select low, sampled after verify delay
// - id mode: high voltage on tenth line, others low except two lowest
// - decode select per device, gate common to read strobe
`timescale 1ns/100ps
`default_nettype none
`include "otpc_map.svh"

module otpc_host
  import otpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire otpc_pkg::otpc_cmd_t cmd_op,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_fail,
  output logic [15:0] rsp_addr,
  output logic [15:0] address_bus,
  input wire logic [7:0] data_lines_i,
  output logic [7:0] data_lines_o,
  output logic data_lines_oe,
  output logic chip_select_n,
  output logic out_gate_n,
  output logic prog_voltage_en,
  output logic id_high_voltage
);
  import otpc_pkg::*;

  // ****************************************
  // sequencer
  // ****************************************
  typedef enum {
    ST_IDLE,
    ST_READ,
    ST_PSETUP,
    ST_PULSE,
    ST_PREC,
    ST_VERIFY,
    ST_DONE
  } otpc_state_t;

  otpc_state_t state_q;
  otpc_cmd_t op_q;
  logic [`OTPC_CNT_W-1:0] cnt_q;
  logic [`OTPC_PCNT_W-1:0] pulses_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic fail_q;
  logic rsp_q;
  logic sweep_q;

  // odd parity over the id byte, top bit acting as parity
  function automatic logic odd_parity(input logic [7:0] b);
    odd_parity = ^b;
  endfunction

  assign cmd_ready = (state_q == ST_IDLE);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      op_q <= OTPC_CMD_READ;
      cnt_q <= '0;
      pulses_q <= '0;
      addr_q <= 16'h0000;
      wdata_q <= 8'hff;
      rdata_q <= 8'h00;
      fail_q <= 1'b0;
      rsp_q <= 1'b0;
      sweep_q <= 1'b0;
    end else begin
      rsp_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (cmd_valid) begin
            op_q <= cmd_op;
            wdata_q <= cmd_wdata;
            fail_q <= 1'b0;
            cnt_q <= '0;
            pulses_q <= '0;
            sweep_q <= (cmd_op == OTPC_CMD_VERIFY_ALL);
            unique case (cmd_op)
              // id: tenth line raised, only the two lowest lines vary
              OTPC_CMD_ID: addr_q <= {14'h0080, cmd_addr[1:0]};
              OTPC_CMD_VERIFY_ALL: addr_q <= 16'h0000;
              default: addr_q <= cmd_addr;
            endcase
            // a byte of all ones needs no pulse at all
            if (cmd_op == OTPC_CMD_PROG && cmd_wdata != `OTPC_ERASED_BYTE)
              state_q <= ST_PSETUP;
            else if (cmd_op == OTPC_CMD_PROG)
              state_q <= ST_DONE;
            else
              state_q <= ST_READ;
          end
        end
        ST_READ: begin
          // wait the access delay with select and gate low
          if (cnt_q == `OTPC_CNT_W'(`OTPC_ACCESS_CYC)) begin
            cnt_q <= '0;
            rdata_q <= data_lines_i;
            if (op_q == OTPC_CMD_ID && addr_q[1] &&
                !odd_parity(data_lines_i))
              fail_q <= 1'b1;
            if (sweep_q) begin
              if (data_lines_i != wdata_q)
                fail_q <= 1'b1;
              if (addr_q == `OTPC_LAST_ADDR || data_lines_i != wdata_q)
                state_q <= ST_DONE;
              else
                addr_q <= addr_q + 16'h0001;
            end else begin
              state_q <= ST_DONE;
            end
          end else begin
            cnt_q <= cnt_q + `OTPC_CNT_W'(1);
          end
        end
        ST_PSETUP: begin
          state_q <= ST_PULSE;
          cnt_q <= '0;
        end
        ST_PULSE: begin
          if (cnt_q == `OTPC_CNT_W'(`OTPC_PULSE_CYC - 1)) begin
            cnt_q <= '0;
            pulses_q <= pulses_q + `OTPC_PCNT_W'(1);
            state_q <= ST_PREC;
          end else begin
            cnt_q <= cnt_q + `OTPC_CNT_W'(1);
          end
        end
        ST_PREC: begin
          state_q <= ST_VERIFY;
        end
        ST_VERIFY: begin
          if (cnt_q == `OTPC_CNT_W'(`OTPC_VERIFY_CYC)) begin
            cnt_q <= '0;
            rdata_q <= data_lines_i;
            if (data_lines_i == wdata_q)
              state_q <= ST_DONE;
            else if (pulses_q == `OTPC_PCNT_W'(`OTPC_MAX_PULSES)) begin
              fail_q <= 1'b1;
              state_q <= ST_DONE;
            end else
              state_q <= ST_PSETUP;
          end else begin
            cnt_q <= cnt_q + `OTPC_CNT_W'(1);
          end
        end
        ST_DONE: begin
          rsp_q <= 1'b1;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  // the voltage qualifiers override gate and tenth line levels
  always_comb begin
    address_bus = addr_q;
    chip_select_n = 1'b1;
    out_gate_n = 1'b1;
    prog_voltage_en = 1'b0;
    id_high_voltage = 1'b0;
    data_lines_oe = 1'b0;
    data_lines_o = wdata_q;
    unique case (state_q)
      ST_READ: begin
        chip_select_n = 1'b0;
        out_gate_n = 1'b0;
        id_high_voltage = (op_q == OTPC_CMD_ID);
        if (op_q == OTPC_CMD_ID)
          address_bus = {14'h0000, addr_q[1:0]};
      end
      ST_PSETUP, ST_PREC: begin
        // select high under voltage inhibits, so data can settle
        prog_voltage_en = 1'b1;
        data_lines_oe = 1'b1;
      end
      ST_PULSE: begin
        prog_voltage_en = 1'b1;
        chip_select_n = 1'b0;
        data_lines_oe = 1'b1;
      end
      ST_VERIFY: begin
        chip_select_n = 1'b0;
        out_gate_n = 1'b0;
      end
      default: ;
    endcase
  end

  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign rsp_fail = fail_q;
  assign rsp_addr = addr_q;

  // ****************************************
  // checks
  // ****************************************
  property p_drive_safe;
    @(posedge sys_clk) disable iff (!rst_n)
    data_lines_oe |-> (prog_voltage_en && !id_high_voltage && out_gate_n);
  endproperty
  a_drive_safe: assert property (p_drive_safe)
    else $error("data driven outside programming");

  property p_pulse_len;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(state_q == ST_PULSE) |-> (!chip_select_n && prog_voltage_en)[*8];
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("programming pulse cut short");

  property p_pulse_end;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(state_q == ST_PULSE) |-> ##[490:510] (state_q == ST_PREC);
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("pulse length out of range");

  property p_verify_after_pulse;
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(state_q == ST_PULSE) |-> ##1 (state_q == ST_VERIFY);
  endproperty
  a_verify_after_pulse: assert property (p_verify_after_pulse)
    else $error("no verify after pulse");

  property p_prog_sel;
    @(posedge sys_clk) disable iff (!rst_n)
    (prog_voltage_en && !chip_select_n) |-> (state_q == ST_PULSE);
  endproperty
  a_prog_sel: assert property (p_prog_sel)
    else $error("unexpected programming condition");

  property p_verify_pins;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_VERIFY) |-> (!chip_select_n && !out_gate_n
      && !prog_voltage_en && !data_lines_oe);
  endproperty
  a_verify_pins: assert property (p_verify_pins)
    else $error("verify pins wrong");

  property p_id_addr;
    @(posedge sys_clk) disable iff (!rst_n)
    id_high_voltage |-> (address_bus[15:2] == 14'h0000);
  endproperty
  a_id_addr: assert property (p_id_addr)
    else $error("id address lines not low");

  property p_standby;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_IDLE) |-> (chip_select_n && out_gate_n
      && !prog_voltage_en && !id_high_voltage);
  endproperty
  a_standby: assert property (p_standby)
    else $error("pins active while idle");

  property p_read_wait;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(state_q == ST_READ) |-> (state_q == ST_READ)[*4];
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read sampled before access delay");
endmodule

`default_nettype wire

// ==== verif/otpc_mem_model.sv ====
/*
 * behavioural model of the 64K x 8 one-time-programmable memory.
 * assumes the bench resolves the shared data lines from the host enable alone.
 */
`timescale 1ns/100ps
`default_nettype none
module otpc_mem_model #(
  parameter logic [7:0] MFR_CODE = 8'h45, // arbitrary value, odd parity
  parameter logic [7:0] DEV_CODE = 8'hc1, // arbitrary value, odd parity
  parameter logic [7:0] CONT_CODE = 8'h5d // arbitrary value
) (
  input wire logic [15:0] address_bus,
  input wire logic [7:0] data_in,
  input wire logic chip_select_n,
  input wire logic out_gate_n,
  input wire logic prog_voltage_en,
  input wire logic id_high_voltage,
  output logic [7:0] data_out,
  output logic data_oe
);
  logic [7:0] mem [0:65535];
  logic [7:0] rd;
  logic [7:0] last = 8'h00;
  initial foreach (mem[i]) mem[i] = 8'hff;
  // programming voltage overrides the gate level
  assign data_oe = !chip_select_n && !out_gate_n
    && !prog_voltage_en;
  always_comb begin
    if (!id_high_voltage) rd = mem[address_bus];
    else if (address_bus[1])
      rd = address_bus[0] ? DEV_CODE : MFR_CODE;
    else rd = CONT_CODE;
  end
  // no pull on the lines: a released bus shows the inverse of its last byte
  always @* if (data_oe) last = rd;
  assign data_out = data_oe ? rd : ~last;
  // bits can only be cleared; a high select inhibits
  always @(posedge chip_select_n)
    if (prog_voltage_en)
      mem[address_bus] = mem[address_bus] & data_in;
endmodule
`default_nettype wire

// ==== verif/otpc_host_bench.sv ====
/*
 * self-checking bench for otpc_host against the memory model.
 * assumes otpc_pkg is compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module otpc_host_bench;
  import otpc_pkg::*;
  localparam logic [7:0] MFR = 8'h45;
  localparam logic [7:0] DEV = 8'hc1;
  localparam logic [7:0] CONT = 8'h5d;
  logic sys_clk = 0, rst_n = 0, cmd_valid = 0;
  otpc_cmd_t cmd_op = OTPC_CMD_READ;
  logic [15:0] cmd_addr = 16'h0000, rsp_addr, address_bus;
  logic [7:0] cmd_wdata = 8'h00, rsp_rdata, data_lines_o, data_lines_i;
  logic [7:0] mem_out;
  logic cmd_ready, rsp_valid, rsp_fail, data_lines_oe, chip_select_n;
  logic out_gate_n, prog_voltage_en, id_high_voltage, mem_oe;
  int error_cnt = 0, n_checks = 0;
  logic [7:0] shadow [logic [15:0]];
  assign data_lines_i = data_lines_oe ? data_lines_o : mem_out;
  otpc_host uut (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_fail(rsp_fail), .rsp_addr(rsp_addr), .address_bus(address_bus),
    .data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
    .data_lines_oe(data_lines_oe), .chip_select_n(chip_select_n),
    .out_gate_n(out_gate_n), .prog_voltage_en(prog_voltage_en),
    .id_high_voltage(id_high_voltage));
  otpc_mem_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .CONT_CODE(CONT)) u_mem (
    .address_bus(address_bus), .data_in(data_lines_i),
    .chip_select_n(chip_select_n), .out_gate_n(out_gate_n),
    .prog_voltage_en(prog_voltage_en), .id_high_voltage(id_high_voltage),
    .data_out(mem_out), .data_oe(mem_oe));
  initial forever #20 sys_clk = ~sys_clk;
  // ****************************************
  // checks and bus tasks
  // ****************************************
  task automatic wrap_up;
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e,
    input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [15:0] a);
    return shadow.exists(a) ? shadow[a] : 8'hff;
  endfunction
  // a full pulse budget runs about 12.7k cycles, so 20k bounds any command short of a full-memory sweep
  task automatic run(input otpc_cmd_t op, input logic [15:0] a,
    input logic [7:0] d);
    int n;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    n = 0;
    // ready is looked at off the edge; the next rising edge takes it
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    chk("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
  endtask
  task automatic rd(input logic [15:0] a);
    run(OTPC_CMD_READ, a, 8'h00);
    chk("rdata", {8'h00, exp_rd(a)}, {8'h00, rsp_rdata});
  endtask
  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    logic f;
    f = (exp_rd(a) & d) !== d;
    shadow[a] = exp_rd(a) & d;
    run(OTPC_CMD_PROG, a, d);
    chk("prog_fail", {15'h0000, f}, {15'h0000, rsp_fail});
    chk("prog_addr", a, rsp_addr);
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    int i;
    logic [7:0] e;
    void'($urandom(32'h2bf1));
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    chk("idle_pins", 16'h0018, {11'h000, chip_select_n, out_gate_n,
      prog_voltage_en, id_high_voltage, data_lines_oe});
    rd(16'h0000);
    rd(16'hffff);
    for (i = 0; i < 4; i++) begin
      e = i[1] ? (i[0] ? DEV : MFR) : CONT;
      run(OTPC_CMD_ID, i[15:0], 8'h00);
      chk("id_byte", {8'h00, e}, {8'h00, rsp_rdata});
      chk("id_fail", 16'h0000, {15'h0000, rsp_fail});
      if (i[1]) chk("id_parity", 16'h0001, {15'h0000, ^rsp_rdata});
    end
    prog(16'h0003, 8'hf0);
    prog(16'h0003, 8'h30);
    rd(16'h0003);
    prog(16'h0003, 8'h0f);
    rd(16'h0003);
    prog(16'h0004, 8'hff);
    for (i = 0; i < 6; i++) begin
      cmd_addr = 16'($urandom % 65000) + 16'h0010;
      prog(cmd_addr, 8'($urandom));
      rd(cmd_addr);
      rd(16'($urandom));
    end
    run(OTPC_CMD_VERIFY_ALL, 16'h0000, 8'hff);
    chk("sweep_fail", 16'h0001, {15'h0000, rsp_fail});
    chk("sweep_addr", 16'h0003, rsp_addr);
    wrap_up;
  end
  // the tests need about 17k cycles, the failing program most of them
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    wrap_up;
  end
  // host and memory must never drive the data lines at once
  always @(negedge sys_clk)
    if (rst_n)
      chk("bus_clash", 16'h0000, {15'h0000, data_lines_oe & mem_oe});
endmodule
`default_nettype wire
